// ==== hw/csel_pkg.sv ====
// Constants and types shared by the clock source selection block
package csel_pkg;
	// Register addresses on the special-function register port
	localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT = 8'hA9;
	localparam logic [7:0] ADDR_HF_OSC_CONTROL = 8'hB2;
	localparam logic [7:0] ADDR_HF_OSC_CALIBRATION = 8'hB3;

	// Field positions in clock_source_select
	localparam int USB_SRC_LSB = 4;
	localparam int USB_SRC_MSB = 6;
	localparam int OUT_STYLE_BIT = 3;
	localparam int SYS_SRC_LSB = 0;
	localparam int SYS_SRC_MSB = 2;

	// Field positions in hf_osc_control
	localparam int HF_EN_BIT = 7;
	localparam int HF_RDY_BIT = 6;
	localparam int HF_SUSP_BIT = 5;
	localparam int HF_DIV_LSB = 0;
	localparam int HF_DIV_MSB = 1;

	// Reset values and calibration mask
	localparam logic [7:0] RST_CLOCK_SOURCE_SELECT = 8'h00;
	localparam logic RST_HF_EN = 1'b1;
	localparam logic [1:0] RST_HF_DIV = 2'h0;
	localparam logic [6:0] CAL_MASK = 7'h7F;

	// System clock source codes
	localparam logic [2:0] SYS_HF_POSTDIV = 3'h0;
	localparam logic [2:0] SYS_EXT = 3'h1;
	localparam logic [2:0] SYS_HF_DIV2 = 3'h2;
	localparam logic [2:0] SYS_HF = 3'h3;
	localparam logic [2:0] SYS_LF = 3'h4;

	// USB clock source codes
	localparam logic [2:0] USB_HF = 3'h0;
	localparam logic [2:0] USB_HF_DIV8 = 3'h1;
	localparam logic [2:0] USB_EXT = 3'h2;
	localparam logic [2:0] USB_EXT_DIV2 = 3'h3;
	localparam logic [2:0] USB_EXT_DIV3 = 3'h4;
	localparam logic [2:0] USB_EXT_DIV4 = 3'h5;
	localparam logic [2:0] USB_LF = 3'h6;

	// Divider ratios
	localparam int RATIO_W = 6;
	localparam logic [RATIO_W-1:0] RATIO_HF_PRE = 6'h04;
	localparam logic [RATIO_W-1:0] RATIO_1 = 6'h01;
	localparam logic [RATIO_W-1:0] RATIO_2 = 6'h02;
	localparam logic [RATIO_W-1:0] RATIO_3 = 6'h03;
	localparam logic [RATIO_W-1:0] RATIO_4 = 6'h04;
	localparam logic [RATIO_W-1:0] RATIO_8 = 6'h08;

	// Oscillator index used by the path multiplexers
	localparam logic [1:0] OSC_HF = 2'h0;
	localparam logic [1:0] OSC_EXT = 2'h1;
	localparam logic [1:0] OSC_LF = 2'h2;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		SW_RUN = 2'b01,
		SW_HOLD = 2'b10
	} csel_sw_state_t;
endpackage

// ==== hw/csel_div_if.sv ====
// Control bundle between a clock path and its edge divider
`timescale 1ns/1ps
interface csel_div_if;
	import csel_pkg::*;
	logic src;
	logic [RATIO_W-1:0] ratio;
	logic hold;
	logic out;
	modport ctl (output src, output ratio, output hold, input out);
	modport div (input src, input ratio, input hold, output out);
endinterface

// ==== hw/csel_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module csel_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	import csel_pkg::*;
	logic [WIDTH-1:0] stage [SYNC_STAGES];

	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= pin;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			level <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage[1][i] == stage[2][i]) begin
					level[i] <= stage[2][i];
				end
			end
		end
	end
endmodule

// ==== hw/csel_clkdiv.sv ====
// Edge-counting divider for an oscillator level sampled on the core clock
`timescale 1ns/1ps
module csel_clkdiv (
	input wire logic core_clk,
	input wire logic resetn,
	csel_div_if.div dv
);
	import csel_pkg::*;
	logic src_d;
	logic [RATIO_W-1:0] cnt;
	logic [RATIO_W-1:0] next_cnt;
	logic rise;

	assign rise = dv.src & ~src_d;
	assign next_cnt = (cnt >= dv.ratio - RATIO_1) ? '0 : cnt + RATIO_1;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			src_d <= 1'b0;
		end else begin
			src_d <= dv.src;
		end
	end

	// Hold parks the count so the first edge after release starts a full high phase
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			dv.out <= 1'b0;
		end else if (dv.hold) begin
			cnt <= dv.ratio - RATIO_1;
			dv.out <= 1'b0;
		end else if (dv.ratio <= RATIO_1) begin
			cnt <= '0;
			dv.out <= dv.src;
		end else if (rise) begin
			cnt <= next_cnt;
			dv.out <= (next_cnt < (dv.ratio >> 1));
		end
	end
endmodule

// ==== hw/csel_top.sv ====
// Clock source selection, high-frequency oscillator control and suspend gating
// What this block does
// - USB clock field bits 6:4 picks HF, HF/8, ext, ext/2, /3, /4, LF.
// - Select register bit 7 reads zero; writes to it are ignored.
// - Bit 3 chooses raw or port-resynchronised system clock on the crossbar output.
// - System code 001 external, 010 HF divided by two, 011 undivided HF.
// - System code 000 takes HF through divide-by-four then the post-divider.
// - System code 100 takes LF oscillator after its programmable divider.
// - After reset the system clock runs from HF path, select fields zero.
// - Post-divider after divide-by-four offers only ratios 1, 2, 4, 8.
// - Post-divider resets to divide-by-eight, 1.5 MHz from 48 MHz.
// - Writing one to control bit 5 suspends the internal oscillator.
// - Suspended on internal source, CPU and peripheral clocks stop until wake.
// - Wake restarts oscillator, CPU and peripherals; CPU continues after suspending write.
// - USB wake detection works during suspend even with transceiver disabled.
// - Calibration bits 6:0 set period; zero fastest, all ones slowest.
// - Calibration loads factory trim on the first cycle after reset release; bit 7 reads zero.
// - Post-divider codes 00 /8, 01 /4, 10 /2, 11 /1.
`timescale 1ns/1ps
module csel_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic hf_osc_in,
	input wire logic ext_osc_in,
	input wire logic lf_osc_in,
	input wire logic [1:0] lf_divider,
	input wire logic vbus_in,
	input wire logic usb_activity_in,
	input wire logic [6:0] factory_trim,
	input wire logic crossbar_clk_en,
	output logic system_clock,
	output logic usb_clock,
	output logic crossbar_clk_out,
	output logic cpu_clk_run,
	output logic periph_clk_run,
	output logic hf_osc_run,
	output logic [6:0] hf_osc_trim
);
	import csel_pkg::*;

	localparam int NPATH = 2;
	localparam int SYS = 0;
	localparam int USB = 1;

	logic [2:0] usb_clock_source_field;
	logic crossbar_clock_out_style;
	logic [2:0] system_clock_source_field;
	logic hf_osc_enable;
	logic suspended;
	logic [1:0] hf_post_divider;
	logic [6:0] cal;
	logic trim_loaded;
	logic [4:0] pin_level;
	logic hf_s;
	logic ext_s;
	logic lf_s;
	logic vbus_s;
	logic usb_act_s;
	logic vbus_d;
	logic wake;
	logic clk_stop;
	logic sys_from_hf;
	logic port_sync;
	logic wr_sel;
	logic wr_ctl;
	logic wr_cal;
	logic [1:0] want_osc [NPATH];
	logic [RATIO_W-1:0] want_ratio [NPATH];
	logic [1:0] act_osc [NPATH];
	logic [RATIO_W-1:0] act_ratio [NPATH];
	csel_sw_state_t sw_state [NPATH];
	logic [NPATH-1:0] div_out;

	assign wr_sel = sfr_wr && (sfr_addr == ADDR_CLOCK_SOURCE_SELECT);
	assign wr_ctl = sfr_wr && (sfr_addr == ADDR_HF_OSC_CONTROL);
	assign wr_cal = sfr_wr && (sfr_addr == ADDR_HF_OSC_CALIBRATION);

	csel_sync #(
		.WIDTH(5)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin({usb_activity_in, vbus_in, lf_osc_in, ext_osc_in, hf_osc_in}),
		.level(pin_level)
	);
	assign {usb_act_s, vbus_s, lf_s, ext_s, hf_s} = pin_level;

	// Select register; reserved codes leave the field untouched
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			usb_clock_source_field <= RST_CLOCK_SOURCE_SELECT[USB_SRC_MSB:USB_SRC_LSB];
			crossbar_clock_out_style <= RST_CLOCK_SOURCE_SELECT[OUT_STYLE_BIT];
			system_clock_source_field <= RST_CLOCK_SOURCE_SELECT[SYS_SRC_MSB:SYS_SRC_LSB];
		end else if (wr_sel) begin
			if (sfr_wdata[USB_SRC_MSB:USB_SRC_LSB] <= USB_LF) begin
				usb_clock_source_field <= sfr_wdata[USB_SRC_MSB:USB_SRC_LSB];
			end
			crossbar_clock_out_style <= sfr_wdata[OUT_STYLE_BIT];
			if (sfr_wdata[SYS_SRC_MSB:SYS_SRC_LSB] <= SYS_LF) begin
				system_clock_source_field <= sfr_wdata[SYS_SRC_MSB:SYS_SRC_LSB];
			end
		end
	end

	// Oscillator control: enable and post-divider
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hf_osc_enable <= RST_HF_EN;
			hf_post_divider <= RST_HF_DIV;
		end else if (wr_ctl) begin
			hf_osc_enable <= sfr_wdata[HF_EN_BIT];
			hf_post_divider <= sfr_wdata[HF_DIV_MSB:HF_DIV_LSB];
		end
	end

	// Suspend flag; a suspending write beats a wake in the same cycle
	assign wake = usb_act_s || (vbus_s != vbus_d);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			suspended <= 1'b0;
			vbus_d <= 1'b0;
		end else begin
			vbus_d <= vbus_s;
			if (wr_ctl && sfr_wdata[HF_SUSP_BIT]) begin
				suspended <= 1'b1;
			end else if (wake) begin
				suspended <= 1'b0;
			end
		end
	end

	// Trim is sampled after reset release, never under the reset itself
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cal <= '0;
			trim_loaded <= 1'b0;
		end else if (!trim_loaded) begin
			cal <= factory_trim & CAL_MASK;
			trim_loaded <= 1'b1;
		end else if (wr_cal) begin
			cal <= sfr_wdata[6:0];
		end
	end

	// Requested source and ratio per path
	always_comb begin
		want_osc[SYS] = OSC_HF;
		want_ratio[SYS] = RATIO_HF_PRE << (2'h3 - hf_post_divider);
		case (system_clock_source_field)
			SYS_HF_POSTDIV: begin
				want_osc[SYS] = OSC_HF;
			end
			SYS_EXT: begin
				want_osc[SYS] = OSC_EXT;
				want_ratio[SYS] = RATIO_1;
			end
			SYS_HF_DIV2: begin
				want_osc[SYS] = OSC_HF;
				want_ratio[SYS] = RATIO_2;
			end
			SYS_HF: begin
				want_osc[SYS] = OSC_HF;
				want_ratio[SYS] = RATIO_1;
			end
			SYS_LF: begin
				want_osc[SYS] = OSC_LF;
				want_ratio[SYS] = RATIO_1 << lf_divider;
			end
			default: begin
				want_osc[SYS] = act_osc[SYS];
				want_ratio[SYS] = act_ratio[SYS];
			end
		endcase
	end

	always_comb begin
		want_osc[USB] = OSC_HF;
		want_ratio[USB] = RATIO_1;
		case (usb_clock_source_field)
			USB_HF: begin
				want_osc[USB] = OSC_HF;
			end
			USB_HF_DIV8: begin
				want_ratio[USB] = RATIO_8;
			end
			USB_EXT: begin
				want_osc[USB] = OSC_EXT;
			end
			USB_EXT_DIV2: begin
				want_osc[USB] = OSC_EXT;
				want_ratio[USB] = RATIO_2;
			end
			USB_EXT_DIV3: begin
				want_osc[USB] = OSC_EXT;
				want_ratio[USB] = RATIO_3;
			end
			USB_EXT_DIV4: begin
				want_osc[USB] = OSC_EXT;
				want_ratio[USB] = RATIO_4;
			end
			USB_LF: begin
				want_osc[USB] = OSC_LF;
			end
			default: begin
				want_osc[USB] = act_osc[USB];
				want_ratio[USB] = act_ratio[USB];
			end
		endcase
	end

	// Each path switches only while its output is low, then restarts clean
	for (genvar p = 0; p < NPATH; p++) begin : g_path
		csel_div_if dif ();

		assign dif.src = (act_osc[p] == OSC_EXT) ? ext_s :
			(act_osc[p] == OSC_LF) ? lf_s : hf_s;
		assign dif.ratio = act_ratio[p];
		assign dif.hold = (sw_state[p] == SW_HOLD);
		assign div_out[p] = dif.out;

		csel_clkdiv u_div (
			.core_clk(core_clk),
			.resetn(resetn),
			.dv(dif)
		);

		always_ff @(posedge core_clk or negedge resetn) begin
			if (!resetn) begin
				sw_state[p] <= SW_HOLD;
				act_osc[p] <= OSC_HF;
				act_ratio[p] <= (p == SYS) ? RATIO_HF_PRE << 2'h3 : RATIO_1;
			end else begin
				case (sw_state[p])
					SW_RUN: begin
						if ((want_osc[p] != act_osc[p] || want_ratio[p] != act_ratio[p])
							&& !dif.out) begin
							sw_state[p] <= SW_HOLD;
							act_osc[p] <= want_osc[p];
							act_ratio[p] <= want_ratio[p];
						end
					end
					SW_HOLD: begin
						sw_state[p] <= SW_RUN;
					end
					default: begin
						sw_state[p] <= SW_HOLD;
					end
				endcase
			end
		end
	end

	assign sys_from_hf = (act_osc[SYS] == OSC_HF);
	assign clk_stop = suspended && sys_from_hf;

	// Clock and gate outputs, all registered
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			system_clock <= 1'b0;
			usb_clock <= 1'b0;
			cpu_clk_run <= 1'b1;
			periph_clk_run <= 1'b1;
			hf_osc_run <= RST_HF_EN;
			hf_osc_trim <= '0;
		end else begin
			system_clock <= div_out[SYS] && !clk_stop;
			usb_clock <= div_out[USB];
			cpu_clk_run <= !clk_stop;
			periph_clk_run <= !clk_stop;
			hf_osc_run <= hf_osc_enable && !suspended;
			hf_osc_trim <= cal;
		end
	end

	// Resynchronised copy lags the raw output by two cycles, matching port output timing
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			port_sync <= 1'b0;
			crossbar_clk_out <= 1'b0;
		end else begin
			port_sync <= system_clock;
			if (!crossbar_clk_en) begin
				crossbar_clk_out <= 1'b0;
			end else if (crossbar_clock_out_style) begin
				crossbar_clk_out <= port_sync;
			end else begin
				crossbar_clk_out <= div_out[SYS] && !clk_stop;
			end
		end
	end

	// Read port; unmapped addresses answer zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata <= '0;
		end else if (sfr_rd) begin
			case (sfr_addr)
				ADDR_CLOCK_SOURCE_SELECT: begin
					sfr_rdata <= {1'b0, usb_clock_source_field, crossbar_clock_out_style,
						system_clock_source_field};
				end
				ADDR_HF_OSC_CONTROL: begin
					sfr_rdata <= {hf_osc_enable, hf_osc_enable && !suspended, suspended,
						3'h0, hf_post_divider};
				end
				ADDR_HF_OSC_CALIBRATION: begin
					sfr_rdata <= {1'b0, cal};
				end
				default: begin
					sfr_rdata <= 8'h00;
				end
			endcase
		end
	end
endmodule

// ==== tb/csel_assertions.sv ====
// Port-level checks for the clock select block
`timescale 1ns/1ps
module csel_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic vbus_in,
	input wire logic usb_activity_in,
	input wire logic crossbar_clk_en,
	input wire logic system_clock,
	input wire logic crossbar_clk_out,
	input wire logic cpu_clk_run,
	input wire logic periph_clk_run,
	input wire logic hf_osc_run,
	input wire logic [6:0] hf_osc_trim
);
	import csel_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_gate_pair;
		cpu_clk_run == periph_clk_run;
	endproperty
	a_gate_pair: assert property (p_gate_pair) else $error("cpu and periph gating differ");
	property p_susp;
		sfr_wr && sfr_addr == ADDR_HF_OSC_CONTROL && sfr_wdata[HF_SUSP_BIT] && !usb_activity_in
			|-> ##[1:3] !hf_osc_run;
	endproperty
	a_susp: assert property (p_susp) else $error("oscillator not suspended");
	property p_sys_stop;
		!cpu_clk_run [*3] |-> !system_clock;
	endproperty
	a_sys_stop: assert property (p_sys_stop) else $error("system clock runs in suspend");
	property p_usb_wake;
		!cpu_clk_run && usb_activity_in |-> ##[1:8] cpu_clk_run;
	endproperty
	a_usb_wake: assert property (p_usb_wake) else $error("no wake on usb activity");
	property p_vbus_wake;
		!cpu_clk_run && $changed(vbus_in) |-> ##[1:8] cpu_clk_run;
	endproperty
	a_vbus_wake: assert property (p_vbus_wake) else $error("no wake on vbus edge");
	property p_trim;
		sfr_wr && sfr_addr == ADDR_HF_OSC_CALIBRATION |-> ##2 hf_osc_trim == 7'($past(sfr_wdata, 2));
	endproperty
	a_trim: assert property (p_trim) else $error("trim output not written value");
	property p_bit7;
		sfr_rd && (sfr_addr == ADDR_CLOCK_SOURCE_SELECT || sfr_addr == ADDR_HF_OSC_CALIBRATION)
			|=> !sfr_rdata[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 reads one");
	property p_xbar_off;
		!crossbar_clk_en [*3] |-> !crossbar_clk_out;
	endproperty
	a_xbar_off: assert property (p_xbar_off) else $error("crossbar clock while disabled");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock select block
`timescale 1ns/1ps
module tb_top;
	import csel_pkg::*;
	// Trim strap value is arbitrary
	localparam logic [6:0] TRIM = 7'h55;
	logic core_clk, resetn, sfr_wr, sfr_rd, vbus_in, usb_activity_in, crossbar_clk_en;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cnt;
	logic [1:0] lf_divider;
	logic system_clock, usb_clock, crossbar_clk_out, cpu_clk_run, periph_clk_run, hf_osc_run;
	logic [6:0] hf_osc_trim;
	int bad_count, tests_run;
	int se[5] = '{0, 8, 8, 4, 64};
	int ue[7] = '{4, 32, 8, 16, 24, 32, 16};
	// Oscillators as counter bits: HF period 4, ext 8, LF 16 core cycles
	csel_top u_dut (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.hf_osc_in(cnt[1]), .ext_osc_in(cnt[2]), .lf_osc_in(cnt[3]), .lf_divider(lf_divider),
		.vbus_in(vbus_in), .usb_activity_in(usb_activity_in), .factory_trim(TRIM),
		.crossbar_clk_en(crossbar_clk_en), .system_clock(system_clock), .usb_clock(usb_clock),
		.crossbar_clk_out(crossbar_clk_out), .cpu_clk_run(cpu_clk_run),
		.periph_clk_run(periph_clk_run), .hf_osc_run(hf_osc_run), .hf_osc_trim(hf_osc_trim));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cnt <= cnt + 8'h01;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		#1;
		chk(sfr_rdata, e);
	endtask
	// Period between second and third rising edge; first may be a switch transient
	task meas(input int s, input int e);
		int n, r;
		logic p, c;
		n = 0;
		r = 0;
		p = 1'b1;
		while (r < 3 && n < 2000) begin
			@(posedge core_clk);
			#1;
			c = (s == 0) ? system_clock : (s == 1) ? usb_clock : crossbar_clk_out;
			n++;
			if (c && !p) begin
				r++;
				if (r == 2) n = 0;
			end
			p = c;
		end
		// Clamp so a long period cannot alias onto a short one
		chk((n > 255) ? 8'hFF : 8'(n), 8'(e));
	endtask
	task runs(input logic [2:0] e);
		repeat (10) @(posedge core_clk);
		chk({5'h0, cpu_clk_run, periph_clk_run, hf_osc_run}, {5'h0, e});
	endtask
	task end_sim;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		end_sim();
	end
	initial begin
		resetn = 1'b0;
		cnt = 8'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		vbus_in = 1'b0;
		usb_activity_in = 1'b0;
		crossbar_clk_en = 1'b0;
		lf_divider = 2'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk({1'b0, hf_osc_trim}, {1'b0, TRIM});
		rd(ADDR_CLOCK_SOURCE_SELECT, 8'h00);
		rd(ADDR_HF_OSC_CONTROL, 8'hC0);
		rd(ADDR_HF_OSC_CALIBRATION, {1'b0, TRIM});
		rd(8'h00, 8'h00);
		meas(0, 128);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_HF_OSC_CONTROL, 8'h80 | 8'(p));
			rd(ADDR_HF_OSC_CONTROL, 8'hC0 | 8'(p));
			meas(0, 128 >> p);
		end
		lf_divider <= 2'h2;
		for (int c = 1; c < 5; c++) begin
			wr(ADDR_CLOCK_SOURCE_SELECT, 8'(c));
			rd(ADDR_CLOCK_SOURCE_SELECT, 8'(c));
			meas(0, se[c]);
		end
		lf_divider <= 2'h0;
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_CLOCK_SOURCE_SELECT, 8'(c << 4) | 8'h03);
			rd(ADDR_CLOCK_SOURCE_SELECT, 8'(c << 4) | 8'h03);
			meas(1, ue[c]);
		end
		// Reserved codes must leave old selections in place
		wr(ADDR_CLOCK_SOURCE_SELECT, 8'hF7);
		rd(ADDR_CLOCK_SOURCE_SELECT, 8'h63);
		meas(1, 16);
		wr(ADDR_CLOCK_SOURCE_SELECT, 8'h8D);
		rd(ADDR_CLOCK_SOURCE_SELECT, 8'h0B);
		meas(0, 4);
		crossbar_clk_en <= 1'b1;
		meas(2, 4);
		wr(ADDR_CLOCK_SOURCE_SELECT, 8'h03);
		meas(2, 4);
		crossbar_clk_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk({7'h0, crossbar_clk_out}, 8'h00);
		// Trim follows calibration writes, here made with the oscillator off
		wr(ADDR_HF_OSC_CONTROL, 8'h03);
		wr(ADDR_HF_OSC_CALIBRATION, 8'hFF);
		rd(ADDR_HF_OSC_CALIBRATION, 8'h7F);
		chk({1'b0, hf_osc_trim}, 8'h7F);
		wr(ADDR_HF_OSC_CALIBRATION, 8'h00);
		repeat (3) @(posedge core_clk);
		chk({1'b0, hf_osc_trim}, 8'h00);
		wr(ADDR_HF_OSC_CONTROL, 8'h83);
		// Suspend on internal source, usb wake and vbus edge wake
		wr(ADDR_HF_OSC_CONTROL, 8'hA3);
		runs(3'h0);
		rd(ADDR_HF_OSC_CONTROL, 8'hA3);
		chk({7'h0, system_clock}, 8'h00);
		usb_activity_in <= 1'b1;
		runs(3'h7);
		usb_activity_in <= 1'b0;
		rd(ADDR_HF_OSC_CONTROL, 8'hC3);
		meas(0, 4);
		wr(ADDR_HF_OSC_CONTROL, 8'hA3);
		runs(3'h0);
		vbus_in <= 1'b1;
		runs(3'h7);
		wr(ADDR_HF_OSC_CONTROL, 8'hA3);
		runs(3'h0);
		vbus_in <= 1'b0;
		runs(3'h7);
		// External source keeps cpu clock through suspend
		wr(ADDR_CLOCK_SOURCE_SELECT, 8'h01);
		wr(ADDR_HF_OSC_CONTROL, 8'hA3);
		runs(3'h6);
		usb_activity_in <= 1'b1;
		runs(3'h7);
		usb_activity_in <= 1'b0;
		end_sim();
	end
endmodule
bind csel_top csel_assertions u_chk (.core_clk(core_clk), .resetn(resetn),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .vbus_in(vbus_in), .usb_activity_in(usb_activity_in),
	.crossbar_clk_en(crossbar_clk_en), .system_clock(system_clock),
	.crossbar_clk_out(crossbar_clk_out), .cpu_clk_run(cpu_clk_run),
	.periph_clk_run(periph_clk_run), .hf_osc_run(hf_osc_run), .hf_osc_trim(hf_osc_trim));
